// file: tb/file_mem_model.sv
// file register memory standing on the far side of the exec block
// assumes write-backs land one edge after they appear on result
`timescale 1ns/10ps
`default_nettype none
module file_mem_model
	import exec_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [FADDR_W-1:0] readAddr,
	input wire result_t result,
	output logic [DATA_W-1:0] fileValue
);
	logic [DATA_W-1:0] mem [128];
	// seeded one step from zero so skips and zero flags fire often
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = i[0] ? 8'hff : 8'h01;
		end
	end
	// pending write forwarded, as the real operand path must do
	assign fileValue = (result.fileWe && result.fileAddr == readAddr) ?
		result.fileData : mem[readAddr];
	always @(posedge ref_clk) begin
		if (result.fileWe) begin
			mem[result.fileAddr] <= result.fileData;
		end
	end
endmodule : file_mem_model
`default_nettype wire

// file: tb/testbench.sv
// random self-checking bench for the call and file-update exec block
// assumes one cycle answer and one flush cycle after call or zero skip
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import exec_unit_pkg::*;
	localparam int N = 400;
	typedef struct packed {logic busy; result_t res;} note_t;
	logic ref_clk = 0, reset = 1, flush = 0, busy;
	instr_t instr = '0;
	logic [PC_W-1:0] pcNow = '0;
	logic [DATA_W-1:0] upper_pc_holding = '0, fileValue;
	result_t result;
	note_t notes[$];
	int fails = 0, samples_checked = 0;
	logic [31:0] seed = 32'h754d515d;
	subroutine_file_exec i_dut(.ref_clk(ref_clk), .reset(reset), .instr(instr),
		.fileValue(fileValue), .pcNow(pcNow), .upper_pc_holding(upper_pc_holding),
		.busy(busy), .result(result));
	file_mem_model i_mem(.ref_clk(ref_clk), .readAddr(instr.fileAddr), .result(result),
		.fileValue(fileValue));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// expected answer worked out from the instruction and its operand
	function automatic note_t expect_note(input instr_t i, input logic [DATA_W-1:0] fv);
		note_t n;
		logic [DATA_W-1:0] v;
		n = '0;
		v = ~fv;
		if (i.op inside {OP_ZERO_FILE, OP_ZERO_ACC}) v = ZERO_BYTE;
		if (i.op inside {OP_MINUS_ONE, OP_DOWN_SKIP}) v = fv - ONE_BYTE;
		if (i.op == OP_UP_SKIP) v = fv + ONE_BYTE;
		if (i.valid && i.op == OP_CALL) begin
			n.res.pushWe = 1'b1;
			n.res.pushData = pcNow + 13'h0001;
			n.res.pcLoad = 1'b1;
			n.res.pcData = {upper_pc_holding[LATCH_HI_BIT:LATCH_LO_BIT], i.target};
			n.busy = 1'b1;
		end else if (i.valid && i.op inside {[OP_COMPLEMENT:OP_UP_SKIP]}) begin
			n.res.accWe = i.op == OP_ZERO_ACC || (i.op != OP_ZERO_FILE && !i.dest);
			n.res.accData = v;
			n.res.fileWe = !n.res.accWe;
			n.res.fileAddr = i.fileAddr;
			n.res.fileData = v;
			n.res.zeroWe = i.op inside {[OP_COMPLEMENT:OP_MINUS_ONE]};
			n.res.zeroVal = v == ZERO_BYTE;
			n.busy = i.op inside {OP_DOWN_SKIP, OP_UP_SKIP} && v == ZERO_BYTE;
		end
		return n;
	endfunction : expect_note
	// data fields only count while their strobe is up
	function automatic note_t mask(input note_t n);
		n.res.fileAddr &= {FADDR_W{n.res.fileWe}};
		n.res.fileData &= {DATA_W{n.res.fileWe}};
		n.res.accData &= {DATA_W{n.res.accWe}};
		n.res.zeroVal &= n.res.zeroWe;
		n.res.pushData &= {PC_W{n.res.pushWe}};
		n.res.pcData &= {PC_W{n.res.pcLoad}};
		return n;
	endfunction : mask
	task automatic check(input note_t seen, input note_t exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// driver: new word each falling edge, its note queued for the next rising edge
	initial begin
		note_t n;
		notes.push_back('0);
		repeat (2) @(negedge ref_clk);
		reset = 0;
		for (int k = 0; k < N; k++) begin
			repeat (8) seed = lfsr(seed);
			instr.valid = seed[0] | seed[1];
			instr.op = op_t'({seed[12] & seed[13], seed[4:2]});
			instr.target = seed[15:5];
			instr.fileAddr = seed[16] ? {5'h00, seed[18:17]} : seed[23:17];
			instr.dest = seed[24];
			pcNow = {seed[31:25], seed[5:0]};
			upper_pc_holding = seed[31:24];
			#1;
			n = '0;
			n.res.squash = flush;
			if (!flush) n = expect_note(instr, fileValue);
			flush = n.busy;
			notes.push_back(n);
			@(negedge ref_clk);
		end
		repeat (2) @(negedge ref_clk);
		stop_test();
	end
	// monitor: oldest note against what settled after each rising edge
	always @(posedge ref_clk) begin
		#1;
		if (notes.size() > 0) check(mask({busy, result}), mask(notes.pop_front()));
	end
	initial begin
		#((N + 20) * 10);
		fails++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire

// file: verilog/exec_unit_pkg.sv
// package for the subroutine and file-update execution block
// assumes a 14-bit instruction word and a 13-bit program counter
package exec_unit_pkg;
	localparam int PC_W = 13;
	localparam int FADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int CALL_K_W = 11;
	localparam int LATCH_HI_BIT = 4;
	localparam int LATCH_LO_BIT = 3;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

	// operation codes the fetch stage hands over
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_CALL = 4'h1,
		OP_COMPLEMENT = 4'h2,
		OP_ZERO_FILE = 4'h3,
		OP_ZERO_ACC = 4'h4,
		OP_MINUS_ONE = 4'h5,
		OP_DOWN_SKIP = 4'h6,
		OP_UP_SKIP = 4'h7
	} op_t;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b01,
		ST_FLUSH = 2'b10
	} phase_t;

	// instruction request from fetch
	typedef struct packed {
		logic valid;
		op_t op;
		logic [CALL_K_W-1:0] target;
		logic [FADDR_W-1:0] fileAddr;
		logic dest;
	} instr_t;

	// write-back towards file memory, accumulator and stack
	typedef struct packed {
		logic fileWe;
		logic [FADDR_W-1:0] fileAddr;
		logic [DATA_W-1:0] fileData;
		logic accWe;
		logic [DATA_W-1:0] accData;
		logic zeroWe;
		logic zeroVal;
		logic pushWe;
		logic [PC_W-1:0] pushData;
		logic pcLoad;
		logic [PC_W-1:0] pcData;
		logic squash;
	} result_t;

	typedef struct packed {
		phase_t phase;
		result_t res;
	} state_t;
endpackage : exec_unit_pkg

// file: verilog/subroutine_file_exec.sv
// executes the call, complement, clear, decrement and skip operations
// assumes fetch presents one instruction per cycle with its file operand already read
// Functional notes
// (RQ1) call loads the 11-bit immediate into counter bits 10..0
// (RQ2) call pushes current counter plus one onto the stack head
// (RQ3) call fills counter bits 12..11 from holding register bits 4..3
// (RQ4) call takes two cycles and leaves all status flags untouched
// (RQ5) complement inverts file value, destination bit picks accumulator or file, updates zero
// (RQ6) file clear writes zero to the file and sets zero flag
// (RQ7) accumulator clear writes zero to accumulator and sets zero flag
// (RQ8) decrement subtracts one, steers per destination bit, updates zero flag
// (RQ9) decrement-skip stores result, zero result squashes next instruction, flags untouched
// (RQ10) increment-skip adds one, stores per destination, flags untouched
// (RQ11) increment wrapping to zero squashes next instruction into a no-operation
// (RQ12) complement and decrement set zero when result is zero, else clear
`timescale 1ns/10ps
`default_nettype none
module subroutine_file_exec
	import exec_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire instr_t instr,
	input wire logic [DATA_W-1:0] fileValue,
	input wire logic [PC_W-1:0] pcNow,
	input wire logic [DATA_W-1:0] upper_pc_holding,
	output logic busy,
	output result_t result
);
	state_t cur;
	state_t next_cur;
	logic [DATA_W-1:0] value;
	logic isZero;
	logic taken;

	// steer an 8-bit result to accumulator or file
	function automatic result_t steer(input result_t r, input logic d,
			input logic [FADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		result_t o;
		o = r;
		o.fileAddr = a;
		if (d) begin
			o.fileWe = 1'b1;
			o.fileData = v;
		end else begin
			o.accWe = 1'b1;
			o.accData = v;
		end
		return o;
	endfunction : steer

	// a fresh instruction is not taken while the flushed slot is pending
	assign busy = (cur.phase == ST_FLUSH);
	assign result = cur.res;
	// an instruction counts only when valid outside the flush slot
	assign taken = !busy && instr.valid;

	// arithmetic shared by the file operations
	always_comb begin
		case (instr.op)
			OP_COMPLEMENT: value = ~fileValue; // RQ5
			OP_MINUS_ONE, OP_DOWN_SKIP: value = fileValue - ONE_BYTE; // RQ8 RQ9
			OP_UP_SKIP: value = fileValue + ONE_BYTE; // RQ10
			default: value = ZERO_BYTE;
		endcase
		isZero = (value == ZERO_BYTE);
	end

	// next state: one result per cycle, second cycle of call or zero-result skip is a bubble
	always_comb begin
		next_cur = cur;
		next_cur.res = '0;
		next_cur.phase = ST_EXEC;
		case (cur.phase)
			ST_FLUSH: begin
				// fetched word is discarded, nothing written
				next_cur.res.squash = 1'b1; // RQ4 RQ9 RQ11
			end
			ST_EXEC: begin
				if (instr.valid) begin
					case (instr.op)
						OP_CALL: begin
							next_cur.res.pushWe = 1'b1;
							next_cur.res.pushData = pcNow + PC_W'(1); // RQ2
							next_cur.res.pcLoad = 1'b1;
							next_cur.res.pcData = {upper_pc_holding[LATCH_HI_BIT:LATCH_LO_BIT],
								instr.target}; // RQ1 RQ3
							next_cur.phase = ST_FLUSH; // RQ4
						end
						OP_COMPLEMENT, OP_MINUS_ONE: begin
							next_cur.res = steer(next_cur.res, instr.dest, instr.fileAddr, value);
							next_cur.res.zeroWe = 1'b1;
							next_cur.res.zeroVal = isZero; // RQ12
						end
						OP_ZERO_FILE: begin
							next_cur.res.fileWe = 1'b1;
							next_cur.res.fileAddr = instr.fileAddr;
							next_cur.res.fileData = ZERO_BYTE; // RQ6
							next_cur.res.zeroWe = 1'b1;
							next_cur.res.zeroVal = 1'b1; // RQ6
						end
						OP_ZERO_ACC: begin
							next_cur.res.accWe = 1'b1;
							next_cur.res.accData = ZERO_BYTE; // RQ7
							next_cur.res.zeroWe = 1'b1;
							next_cur.res.zeroVal = 1'b1; // RQ7
						end
						OP_DOWN_SKIP, OP_UP_SKIP: begin
							// no zero flag write: skip ops leave status alone
							next_cur.res = steer(next_cur.res, instr.dest, instr.fileAddr, value);
							if (isZero) begin
								next_cur.phase = ST_FLUSH; // RQ9 RQ11
							end
						end
						default: begin
							next_cur.res = '0;
						end
					endcase
				end
			end
			default: begin
				next_cur.phase = ST_EXEC;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cur.phase <= ST_EXEC;
			cur.res <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// assertions
	call_target_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
		(!busy && instr.valid && instr.op == OP_CALL) |=>
		(result.pcLoad && result.pcData[CALL_K_W-1:0] == $past(instr.target)))
		else $error("call target not loaded");
	call_push_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ2
		(!busy && instr.valid && instr.op == OP_CALL) |=>
		(result.pushWe && result.pushData == $past(pcNow) + PC_W'(1)))
		else $error("return address wrong");
	call_upper_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ3
		(!busy && instr.valid && instr.op == OP_CALL) |=>
		(result.pcData[PC_W-1:CALL_K_W] == $past(upper_pc_holding[LATCH_HI_BIT:LATCH_LO_BIT])))
		else $error("upper counter bits wrong");
	call_two_cycle_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
		(!busy && instr.valid && instr.op == OP_CALL) |=>
		(!result.zeroWe && busy) ##1 (result.squash && !result.zeroWe && !busy))
		else $error("call not two cycles");
	comp_value_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
		(!busy && instr.valid && instr.op == OP_COMPLEMENT && instr.dest) |=>
		(result.fileWe && !result.accWe && result.fileData == ~$past(fileValue)))
		else $error("complement to file wrong");
	clear_file_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
		(!busy && instr.valid && instr.op == OP_ZERO_FILE) |=>
		(result.fileWe && result.fileData == ZERO_BYTE && result.zeroWe && result.zeroVal))
		else $error("file clear wrong");
	clear_acc_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ7
		(!busy && instr.valid && instr.op == OP_ZERO_ACC) |=>
		(result.accWe && result.accData == ZERO_BYTE && result.zeroVal && !result.fileWe))
		else $error("accumulator clear wrong");
	dec_acc_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
		(!busy && instr.valid && instr.op == OP_MINUS_ONE && !instr.dest) |=>
		(result.accWe && result.accData == $past(fileValue) - ONE_BYTE))
		else $error("decrement to accumulator wrong");
	down_skip_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(!busy && instr.valid && instr.op == OP_DOWN_SKIP) |=>
		(!result.zeroWe && (busy == ($past(fileValue) == ONE_BYTE))))
		else $error("decrement skip wrong");
	up_store_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
		(!busy && instr.valid && instr.op == OP_UP_SKIP && instr.dest) |=>
		(result.fileWe && !result.zeroWe && result.fileData == $past(fileValue) + ONE_BYTE))
		else $error("increment skip store wrong");
	up_wrap_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
		(!busy && instr.valid && instr.op == OP_UP_SKIP && fileValue == 8'hff) |=>
		busy ##1 (result.squash && !result.fileWe && !result.accWe))
		else $error("increment wrap not squashed");
	zero_flag_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ12
		(!busy && instr.valid && (instr.op == OP_COMPLEMENT || instr.op == OP_MINUS_ONE)) |=>
		(result.zeroWe && result.zeroVal == ((result.fileWe ? result.fileData
			: result.accData) == ZERO_BYTE)))
		else $error("zero flag wrong");

	// complement: both destinations, address and flag from the operand itself
	comp_to_acc_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
		(taken && instr.op == OP_COMPLEMENT && !instr.dest) |=>
		(result.accWe && !result.fileWe && result.accData == ~$past(fileValue)))
		else $error("complement to accumulator wrong");
	comp_addr_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
		(taken && instr.op == OP_COMPLEMENT && instr.dest) |=>
		(result.fileAddr == $past(instr.fileAddr)))
		else $error("complement file address wrong");
	comp_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ12
		(taken && instr.op == OP_COMPLEMENT) |=>
		(result.zeroWe && result.zeroVal == ($past(fileValue) == 8'hff)))
		else $error("complement zero flag wrong");
	comp_one_cycle_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
		(taken && instr.op == OP_COMPLEMENT) |=>
		(!busy && !result.pcLoad && !result.pushWe))
		else $error("complement not single cycle");

	// decrement and the two clears
	dec_to_file_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
		(taken && instr.op == OP_MINUS_ONE && instr.dest) |=>
		(result.fileWe && !result.accWe && result.fileData == $past(fileValue) - ONE_BYTE))
		else $error("decrement to file wrong");
	dec_addr_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
		(taken && instr.op == OP_MINUS_ONE && instr.dest) |=>
		(result.fileAddr == $past(instr.fileAddr)))
		else $error("decrement file address wrong");
	dec_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ12
		(taken && instr.op == OP_MINUS_ONE) |=>
		(result.zeroWe && result.zeroVal == ($past(fileValue) == ONE_BYTE)))
		else $error("decrement zero flag wrong");
	dec_one_cycle_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
		(taken && instr.op == OP_MINUS_ONE) |=>
		(!busy && !result.pcLoad && !result.pushWe))
		else $error("decrement not single cycle");
	clear_file_addr_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
		(taken && instr.op == OP_ZERO_FILE) |=>
		(!result.accWe && result.fileAddr == $past(instr.fileAddr)))
		else $error("file clear address wrong");
	clear_file_solo_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
		(taken && instr.op == OP_ZERO_FILE) |=>
		(!busy && !result.pushWe && !result.pcLoad))
		else $error("file clear not single cycle");
	clear_acc_flag_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ7
		(taken && instr.op == OP_ZERO_ACC) |=>
		(result.zeroWe && !busy && !result.pushWe && !result.pcLoad))
		else $error("accumulator clear flag wrong");

	// skip operations: stores, both outcomes, never a jump
	down_to_file_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(taken && instr.op == OP_DOWN_SKIP && instr.dest) |=>
		(result.fileWe && !result.accWe && result.fileData == $past(fileValue) - ONE_BYTE))
		else $error("decrement skip to file wrong");
	down_to_acc_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(taken && instr.op == OP_DOWN_SKIP && !instr.dest) |=>
		(result.accWe && !result.fileWe && result.accData == $past(fileValue) - ONE_BYTE))
		else $error("decrement skip to accumulator wrong");
	down_addr_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(taken && instr.op == OP_DOWN_SKIP && instr.dest) |=>
		(result.fileAddr == $past(instr.fileAddr)))
		else $error("decrement skip address wrong");
	down_squash_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(taken && instr.op == OP_DOWN_SKIP && fileValue == ONE_BYTE) |=>
		busy ##1 (result.squash && !result.fileWe && !result.accWe && !result.zeroWe))
		else $error("decrement skip not squashed");
	down_noskip_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(taken && instr.op == OP_DOWN_SKIP && fileValue != ONE_BYTE) |=>
		(!busy && !result.squash))
		else $error("decrement skip taken wrongly");
	up_to_acc_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
		(taken && instr.op == OP_UP_SKIP && !instr.dest) |=>
		(result.accWe && !result.fileWe && !result.zeroWe
			&& result.accData == $past(fileValue) + ONE_BYTE))
		else $error("increment skip to accumulator wrong");
	up_addr_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
		(taken && instr.op == OP_UP_SKIP && instr.dest) |=>
		(result.fileAddr == $past(instr.fileAddr)))
		else $error("increment skip address wrong");
	up_noskip_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
		(taken && instr.op == OP_UP_SKIP && fileValue != 8'hff) |=>
		(!busy && !result.squash))
		else $error("increment skip taken wrongly");
	skip_no_jump_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
		(taken && (instr.op == OP_DOWN_SKIP || instr.op == OP_UP_SKIP)) |=>
		(!result.pcLoad && !result.pushWe))
		else $error("skip redirected the counter");

	// call: whole counter, no side writes, quiet flush slot
	call_full_pc_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ3
		(taken && instr.op == OP_CALL) |=>
		(result.pcData == {$past(upper_pc_holding[LATCH_HI_BIT:LATCH_LO_BIT]),
			$past(instr.target)}))
		else $error("call counter value wrong");
	call_no_write_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
		(taken && instr.op == OP_CALL) |=>
		(!result.fileWe && !result.accWe && !result.zeroWe && !result.squash))
		else $error("call wrote data or flags");
	call_slot_quiet_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
		(taken && instr.op == OP_CALL) |=>
		##1 (!result.pushWe && !result.pcLoad && !result.fileWe && !result.accWe))
		else $error("call second cycle not quiet");

	// flush slot: lasts one cycle, ignores the fetched word, only it squashes
	busy_one_cycle_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
		busy |=> !busy)
		else $error("flush slot longer than one cycle");
	flush_ignores_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
		busy |=>
		(result.squash && !result.fileWe && !result.accWe && !result.zeroWe
			&& !result.pushWe && !result.pcLoad))
		else $error("discarded word was executed");
	squash_after_busy_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		!busy |=> !result.squash)
		else $error("squash without flush slot");

	cover_call_c: cover property (@(posedge ref_clk) disable iff (reset)
		!busy && instr.valid && instr.op == OP_CALL);
	cover_down_skip_c: cover property (@(posedge ref_clk) disable iff (reset)
		!busy && instr.valid && instr.op == OP_DOWN_SKIP && fileValue == ONE_BYTE);
	cover_up_noskip_c: cover property (@(posedge ref_clk) disable iff (reset)
		!busy && instr.valid && instr.op == OP_UP_SKIP && fileValue == ONE_BYTE);
	cover_comp_zero_c: cover property (@(posedge ref_clk) disable iff (reset)
		!busy && instr.valid && instr.op == OP_COMPLEMENT && fileValue == 8'hff);
endmodule : subroutine_file_exec
`default_nettype wire
